/* File: csp_pkg.sv */
/*
  Package for the clocked serial port: register offsets, field positions,
  reset values, timing constants and state enumeration.
  Assumes a single 50 MHz clock and a plain address/strobe register port.
*/
//==========================================================================
//==========================================================================
package csp_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_PORT_SEL = 8'h04;
  localparam logic [7:0] OFF_MODE_A = 8'h05;
  localparam logic [7:0] OFF_DATA_LO = 8'h06;
  localparam logic [7:0] OFF_DATA_HI = 8'h07;
  localparam logic [7:0] OFF_PIN_OPT = 8'h0c;
  localparam logic [7:0] OFF_MODE_B = 8'h28;
  localparam logic [7:0] OFF_STATUS = 8'h30;
  localparam logic [7:0] OFF_START = 8'h31;
  localparam logic [3:0] MODE_A_RST = 4'h0;
  localparam logic [1:0] PORT_SEL_RST = 2'h0;
  localparam logic [3:0] PIN_OPT_RST = 4'h0;
  localparam int CLK_PIN_BIT = 3;
  localparam int PMOS_OFF_BIT = 2;
  localparam int IN_FN_BIT = 1;
  localparam int OUT_FN_BIT = 0;
  localparam int DIV_BIT = 0;
  localparam int IDLE_BIT = 1;
  // Instruction cycle in ns and the derived count of ref_clk cycles.
  localparam int CLK_NS = 20;
  localparam int TCYC_NS = 1000;
  localparam int TCYC_CLKS = (TCYC_NS + CLK_NS - 1) / CLK_NS;
  localparam int MODE_DELAY_TCYC = 2;
  localparam logic [2:0] SRC_SYSCLK = 3'h6;
  localparam logic [2:0] SRC_EXT = 3'h7;
  localparam logic [2:0] BITS_LAST = 3'h7;
  typedef enum logic [1:0] {CSP_START_WAIT, CSP_CLK_WAIT, CSP_XFER, CSP_CONT}
    csp_state_t;
endpackage : csp_pkg

/* File: csp_fifo.sv */
/*
  Small synchronous FIFO, read data registered.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/100ps
`default_nettype none
module csp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic [WIDTH-1:0] dout;
    logic ov;
  } csp_fifo_st_t;
  csp_fifo_st_t s_q, s_d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic push, pop, empty;
  logic [AW:0] used;
  assign empty = (s_q.wp == s_q.rp);
  assign used = s_q.wp - s_q.rp;
  // The output register is one of the DEPTH slots, so the FIFO never holds DEPTH + 1 words.
  assign in_ready = (used + {{AW{1'b0}}, s_q.ov}) < (AW+1)'(DEPTH);
  // A slot is emptied into the output register when the register is free.
  assign pop = !empty && (!s_q.ov || out_ready);
  assign push = in_valid && in_ready;
  assign out_valid = s_q.ov;
  assign out_data = s_q.dout;
  always_comb begin
    s_d = s_q;
    if (push) s_d.wp = s_q.wp + 1'b1;
    if (out_ready && s_q.ov) s_d.ov = 1'b0;
    if (pop) begin
      s_d.dout = mem_q[s_q.rp[AW-1:0]];
      s_d.ov = 1'b1;
      s_d.rp = s_q.rp + 1'b1;
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) s_q <= '0;
    else s_q <= s_d;
  end
  always_ff @(posedge ref_clk) begin
    if (push) mem_q[s_q.wp[AW-1:0]] <= in_data;
  end
endmodule : csp_fifo
`default_nettype wire

/* File: csp_prescaler.sv */
/*
  Prescaler: one-cycle enable per instruction cycle and a free-running count.
  Assumes the 50 MHz ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module csp_prescaler #(
  parameter int TCYC = 50
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Timing outputs
  output logic tcyc_en,
  output logic [12:0] pre_cnt
);
  typedef struct packed {
    logic [15:0] div;
    logic [12:0] cnt;
  } csp_pre_st_t;
  csp_pre_st_t s_q, s_d;
  assign tcyc_en = (s_q.div == 16'(TCYC - 1));
  assign pre_cnt = s_q.cnt;
  always_comb begin
    s_d = s_q;
    s_d.div = tcyc_en ? 16'h0000 : s_q.div + 16'h0001;
    if (tcyc_en) s_d.cnt = s_q.cnt + 13'h0001;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) s_q <= '0;
    else s_q <= s_d;
  end
endmodule : csp_prescaler
`default_nettype wire

/* File: csp_serial_port.sv */
/*
  Clocked serial port: mode registers, start strobe, 8-bit LSB-first
  shifter with internal or external clock, and a 16-word receive FIFO.
  Assumes a single ref_clk; the external clock pin is synchronous to it.
*/
`timescale 1ns/100ps
`default_nettype none
module csp_serial_port
  import csp_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Register port
  input wire logic [csp_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Serial clock pin
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  // Serial data pins
  input wire logic si_in,
  output logic so_out,
  output logic so_oe,
  output logic so_pmos_on,
  // Event and receive stream
  output logic serial_irq_flag,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data
);
  //========================================================================
  // State
  //========================================================================
  typedef struct packed {
    csp_state_t st;
    logic [3:0] mode_a;
    logic [1:0] mode_b;
    logic [1:0] port_sel;
    logic [3:0] pin_opt;
    logic [7:0] shreg;
    logic [2:0] bits;
    logic irq;
    logic sck;
    logic sck_ext_prev;
    logic so;
    logic [1:0] hold;
    logic [7:0] rdata;
    logic push;
  } csp_st_t;
  csp_st_t s_q, s_d;
  logic tcyc_en;
  logic [12:0] pre_cnt;
  logic fifo_in_ready;
  logic wr_mode_a, wr_mode_b, wr_start, internal, tick;
  logic rise, fall, busy, can_tx, can_rx;
  logic [3:0] sel;
  logic [12:0] half_mask;
  logic tick_gated;
  logic irq_set;

  csp_prescaler #(.TCYC(TCYC_CLKS)) u_pre (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .tcyc_en(tcyc_en),
    .pre_cnt(pre_cnt)
  );

  csp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .in_valid(s_q.push),
    .in_ready(fifo_in_ready),
    .in_data(s_q.shreg),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  //========================================================================
  // Decode and clock selection
  //========================================================================
  assign wr_mode_a = reg_wr && (reg_addr == OFF_MODE_A);
  assign wr_mode_b = reg_wr && (reg_addr == OFF_MODE_B);
  assign wr_start = reg_wr && (reg_addr == OFF_START);
  assign internal = (s_q.mode_a[2:0] != SRC_EXT);
  assign busy = (s_q.st == CSP_XFER);
  assign sel = {s_q.mode_b[DIV_BIT], s_q.mode_a[2:0]};
  // Half period mask: table period 4..8192 tcyc, toggling every half.
  always_comb begin
    unique case (sel)
      4'h0: half_mask = 13'h07ff;
      4'h1: half_mask = 13'h01ff;
      4'h2: half_mask = 13'h007f;
      4'h3: half_mask = 13'h001f;
      4'h4: half_mask = 13'h0007;
      4'h5: half_mask = 13'h0001;
      4'h8: half_mask = 13'h0fff;
      4'h9: half_mask = 13'h03ff;
      4'ha: half_mask = 13'h00ff;
      4'hb: half_mask = 13'h003f;
      4'hc: half_mask = 13'h000f;
      4'hd: half_mask = 13'h0003;
      default: half_mask = 13'h0000;
    endcase
  end
  // System clock source toggles every instruction cycle.
  assign tick = (s_q.mode_a[2:0] == SRC_SYSCLK) ? tcyc_en
              : tcyc_en && ((pre_cnt & half_mask) == half_mask);
  assign tick_gated = tick && (s_q.hold == 2'h0) && s_q.mode_a[CLK_PIN_BIT];
  assign fall = internal ? (tick_gated && s_q.sck) : (s_q.sck_ext_prev && !sck_in);
  assign rise = internal ? (tick_gated && !s_q.sck) : (!s_q.sck_ext_prev && sck_in);
  // Port select bits steer direction (00 continuous on internal clock, 01 tx, 10 rx, 11 both).
  assign can_tx = s_q.port_sel[OUT_FN_BIT];
  assign can_rx = s_q.port_sel[IN_FN_BIT];

  //========================================================================
  // Next state
  //========================================================================
  always_comb begin
    s_d = s_q;
    s_d.push = 1'b0;
    irq_set = 1'b0;
    s_d.sck_ext_prev = sck_in;
    s_d.rdata = 8'h00;
    if (tcyc_en && s_q.hold != 2'h0) s_d.hold = s_q.hold - 2'h1;
    // Clock runs in every state except start wait: clock wait, transfer and continuous.
    if (internal && s_q.st != CSP_START_WAIT && (fall || rise)) s_d.sck = !s_q.sck;
    unique case (s_q.st)
      CSP_START_WAIT: s_d.sck = 1'b1;
      CSP_CLK_WAIT: begin
        if (fall) begin
          if (internal && s_q.port_sel == 2'h0) s_d.st = CSP_CONT;
          else s_d.st = CSP_XFER;
        end
      end
      CSP_XFER: begin
        if (rise) begin
          s_d.bits = s_q.bits + 3'h1;
          if (can_rx) s_d.shreg = {si_in, s_q.shreg[7:1]};
          else s_d.shreg = {1'b0, s_q.shreg[7:1]};
          if (s_q.bits == BITS_LAST) begin
            s_d.bits = 3'h0;
            irq_set = 1'b1;
            s_d.push = can_rx && fifo_in_ready;
            s_d.st = internal ? CSP_START_WAIT : CSP_CLK_WAIT;
          end
        end
      end
      CSP_CONT: ;
    endcase
    // Output bit changes on the falling edge, LSB first.
    if (fall && (s_q.st == CSP_CLK_WAIT || busy) && can_tx) s_d.so = s_q.shreg[0];
    if (reg_wr) begin
      unique case (reg_addr)
        OFF_PORT_SEL: s_d.port_sel = reg_wdata[1:0];
        OFF_PIN_OPT: s_d.pin_opt = reg_wdata[3:0];
        OFF_DATA_LO: s_d.shreg[3:0] = reg_wdata[3:0];
        OFF_DATA_HI: s_d.shreg[7:4] = reg_wdata[3:0];
        default: ;
      endcase
    end
    if (wr_mode_b) begin
      s_d.mode_b = reg_wdata[1:0];
      if (!busy) s_d.so = reg_wdata[IDLE_BIT];
    end
    if (wr_start) begin
      s_d.bits = 3'h0;
      if (busy) irq_set = 1'b1;
      s_d.st = CSP_CLK_WAIT;
    end
    if (wr_mode_a) begin
      s_d.mode_a = reg_wdata[3:0];
      s_d.bits = 3'h0;
      s_d.st = CSP_START_WAIT;
      s_d.sck = 1'b1;
      s_d.hold = 2'(MODE_DELAY_TCYC);
      if (busy) irq_set = 1'b1;
    end
    // A set in the same cycle as a clear wins, so no end of transfer is ever lost.
    if (irq_set) s_d.irq = 1'b1;
    else if (reg_wr && reg_addr == OFF_STATUS && reg_wdata[0]) s_d.irq = 1'b0;
    if (reg_rd) begin
      unique case (reg_addr)
        OFF_DATA_LO: s_d.rdata = {4'h0, s_q.shreg[3:0]};
        OFF_DATA_HI: s_d.rdata = {4'h0, s_q.shreg[7:4]};
        OFF_STATUS: s_d.rdata = {3'h0, s_q.bits, busy, s_q.irq};
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.st <= CSP_START_WAIT;
      s_q.mode_a <= MODE_A_RST;
      s_q.port_sel <= PORT_SEL_RST;
      s_q.pin_opt <= PIN_OPT_RST;
      s_q.mode_b <= 2'b00; // Idle bit has no defined value; zero is one.
      s_q.sck <= 1'b1;
      // The clock pin idles high; a low start here would fake an edge after reset.
      s_q.sck_ext_prev <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  //========================================================================
  // Outputs
  //========================================================================
  assign reg_rdata = s_q.rdata;
  assign sck_out = s_q.sck;
  assign sck_oe = s_q.mode_a[CLK_PIN_BIT] && internal;
  assign so_out = s_q.so;
  assign so_oe = s_q.port_sel[OUT_FN_BIT];
  assign so_pmos_on = !s_q.pin_opt[PMOS_OFF_BIT];
  assign serial_irq_flag = s_q.irq;

  //========================================================================
  // Checks
  //========================================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  mode_a_abort_a: assert property (wr_mode_a |=> (s_q.bits == 3'h0 && s_q.st == CSP_START_WAIT))
    else $error("mode A write did not reset the port");
  abort_irq_a: assert property ((wr_mode_a && busy) |=> s_q.irq)
    else $error("abort did not raise the flag");
  mode_hold_a: assert property (wr_mode_a |=> s_q.hold == 2'h2)
    else $error("mode A settle delay not loaded");
  idle_level_a: assert property ((wr_mode_b && !busy) |=> so_out == $past(reg_wdata[1]))
    else $error("idle level did not follow write");
  done_irq_a: assert property ((busy && rise && s_q.bits == 3'h7
    && !wr_mode_a && !wr_start) |=> (s_q.irq && s_q.bits == 3'h0 && s_q.st != CSP_XFER))
    else $error("eighth clock did not end transfer");
  int_stop_a: assert property ((busy && rise && s_q.bits == 3'h7
    && internal && !reg_wr) |=> s_q.st == CSP_START_WAIT)
    else $error("internal clock did not stop");
  ext_wait_a: assert property ((busy && rise && s_q.bits == 3'h7
    && !internal && !reg_wr) |=> s_q.st == CSP_CLK_WAIT)
    else $error("external clock did not return to clock wait");
  sck_park_a: assert property (s_q.st == CSP_START_WAIT |-> sck_out)
    else $error("clock not parked high while waiting for start");
  pmos_ctl_a: assert property ((reg_wr && reg_addr == OFF_PIN_OPT)
    |=> so_pmos_on == !$past(reg_wdata[PMOS_OFF_BIT]))
    else $error("pmos control did not follow write");
  so_dir_a: assert property ((reg_wr && reg_addr == OFF_PORT_SEL)
    |=> so_oe == $past(reg_wdata[OUT_FN_BIT]))
    else $error("output enable did not follow port select");
  mode_settle_a: assert property ((s_q.hold != 2'h0 && internal) |=> $stable(sck_out))
    else $error("clock moved while mode A settles");
  idle_hold_a: assert property ((s_q.st == CSP_START_WAIT && !wr_mode_b)
    |=> $stable(so_out))
    else $error("idle output level moved without a write");
  cont_flag_a: assert property ((s_q.st == CSP_CONT && !reg_wr)
    |=> $stable(serial_irq_flag))
    else $error("flag moved in continuous clock state");
  shift_in_a: assert property ((busy && rise && can_rx && !reg_wr) |=> s_q.shreg[7] == $past(si_in))
    else $error("input bit not shifted in");
  xfer_cv: cover property (wr_start ##[1:1000] (busy && rise && s_q.bits == 3'h7));
  abort_cv: cover property (busy && wr_mode_a);
  cont_cv: cover property (s_q.st == CSP_CONT);
  ext_cv: cover property (!internal && busy && rise && s_q.bits == 3'h7);
  drop_cv: cover property (busy && rise && s_q.bits == 3'h7 && can_rx && !fifo_in_ready);
endmodule : csp_serial_port
`default_nettype wire

/* File: csp_link_partner.sv */
/*
  External serial device on the far side of the port: it shifts one byte
  in and out LSB first, and it can act as the clock master.
  Assumes the bench routes the clock pin to sck and pulses go once a frame.
*/
`timescale 1ns/100ps
`default_nettype none
module csp_link_partner (
  // Clock
  input wire logic ref_clk,
  // Serial pins
  input wire logic sck,
  input wire logic so,
  output logic si,
  output logic ext_sck,
  // Frame control and result
  input wire logic ext_mode,
  input wire logic go,
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte
);
  int idx = 0;
  initial begin
    si = 1'b0;
    ext_sck = 1'b1;
    rx_byte = 8'h00;
  end
  // Drive on the falling edge and capture on the rising edge, LSB first.
  always @(negedge sck) begin
    si <= tx_byte[idx[2:0]];
  end
  always @(posedge sck) begin
    rx_byte <= {so, rx_byte[7:1]};
    idx = idx + 1;
    if (idx == 8) begin
      // After the hold time the line is released; the inverse keeps stale samples visible.
      repeat (4) @(posedge ref_clk);
      si <= ~si;
    end
  end
  // As master: eight pulses, then the clock parks high until the next frame.
  always @(posedge go) begin
    idx = 0;
    if (ext_mode) begin
      repeat (8) begin
        repeat (10) @(posedge ref_clk);
        ext_sck <= 1'b0;
        repeat (10) @(posedge ref_clk);
        ext_sck <= 1'b1;
      end
    end
  end
endmodule : csp_link_partner
`default_nettype wire

/* File: tb_csp_serial_port.sv */
/*
  Bench for the clocked serial port: reset values, register map, pins,
  frames at several clock rates, receive FIFO, abort, external and continuous clock.
  Assumes csp_link_partner on the serial pins and a 50 MHz ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_csp_serial_port;
  import csp_pkg::*;
  // The whole run needs about 0.6 ms; the watchdog allows more than twice that.
  localparam int WD_NS = 1_600_000;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rx_ready = 1'b0;
  logic go = 1'b0;
  logic ext = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] p_tx = 8'h00;
  logic [7:0] reg_rdata, rx_data, p_rx, d;
  logic sck_out, sck_oe, so_out, so_oe, so_pmos_on, serial_irq_flag, rx_valid, si, ext_sck;
  int failures = 0;
  int cmp_count = 0;
  int nfall = 0;
  time tlast = 0;
  time gap = 0;
  logic [7:0] q[$];
  // Address, data, then {sck_oe, so_oe, so_pmos_on, so_out} expected after the write.
  logic [19:0] rows [8] = '{{8'h0c, 8'h04, 4'h0}, {8'h0c, 8'h00, 4'h2}, {8'h28, 8'h02, 4'h3},
    {8'h28, 8'h00, 4'h2}, {8'h04, 8'h01, 4'h6}, {8'h05, 8'h08, 4'he}, {8'h05, 8'h0f, 4'h6},
    {8'h40, 8'hff, 4'h6}};
  // Divider bit, mode low bits, clock period in ref_clk cycles.
  logic [19:0] cfg [4] = '{{1'b0, 3'h6, 16'h0064}, {1'b0, 3'h5, 16'h00c8},
    {1'b1, 3'h5, 16'h0190}, {1'b0, 3'h4, 16'h0320}};
  wire logic sck_pin = sck_oe ? sck_out : ext_sck;

  always #10 ref_clk = ~ref_clk;
  always @(negedge sck_pin) begin
    nfall++;
    gap = $time - tlast;
    tlast = $time;
  end

  csp_serial_port dut_u (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sck_in(sck_pin), .sck_out(sck_out), .sck_oe(sck_oe), .si_in(si), .so_out(so_out),
    .so_oe(so_oe), .so_pmos_on(so_pmos_on), .serial_irq_flag(serial_irq_flag),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data));
  csp_link_partner link_u (.ref_clk(ref_clk), .sck(sck_pin), .so(so_out), .si(si),
    .ext_sck(ext_sck), .ext_mode(ext), .go(go), .tx_byte(p_tx), .rx_byte(p_rx));

  // ======================================================================
  // Bus cycles and checks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  task automatic pulse;
    @(posedge ref_clk);
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
  endtask : pulse

  task automatic wait_irq;
    for (int n = 0; n < 10000 && serial_irq_flag !== 1'b1; n++) begin
      @(posedge ref_clk);
    end
    chk(serial_irq_flag, 1'b1);
  endtask : wait_irq

  task automatic frame(input logic [7:0] td, input logic [7:0] tp);
    wr(OFF_DATA_LO, {4'h0, td[3:0]});
    wr(OFF_DATA_HI, {4'h0, td[7:4]});
    wr(OFF_STATUS, 8'h01);
    p_tx <= tp;
    nfall = 0;
    wr(OFF_START, 8'h00);
    pulse;
    wait_irq;
    repeat (200) @(posedge ref_clk);
    chk(p_rx, td);
    chk(16'(nfall), 16'h0008);
    chk(sck_pin, 1'b1);
    rd(OFF_STATUS, d);
    chk(d, 8'h01);
  endtask : frame

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  // ======================================================================
  // Stimulus
  initial begin
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    #1 chk({sck_out, sck_oe, so_oe, so_pmos_on, so_out, serial_irq_flag}, 6'h24);
    foreach (rows[i]) begin
      wr(rows[i][19:12], rows[i][11:4]);
      #1 chk({sck_oe, so_oe, so_pmos_on, so_out}, rows[i][3:0]);
      rd(rows[i][19:12], d);
      chk(d, 8'h00);
    end
    // Receive side stalls while 17 frames arrive, so the last one meets a full FIFO.
    wr(OFF_PORT_SEL, 8'h03);
    for (int i = 0; i < 17; i++) begin
      if (i < 5) begin
        wr(OFF_MODE_A, {5'h01, cfg[i % 4][18:16]});
        wr(OFF_MODE_B, {7'h00, cfg[i % 4][19]});
        repeat (110) @(posedge ref_clk);
      end
      frame(8'ha5 + 8'(i), 8'h30 + 8'(i));
      if (i < 4) begin
        chk(16'(gap / 20), cfg[i][15:0]);
      end
      if (q.size() < 16) begin
        q.push_back(8'h30 + 8'(i));
      end
    end
    for (int i = 0; i < 16; i++) begin
      repeat (2) @(posedge ref_clk);
      #1 chk({rx_valid, rx_data}, {1'b1, q[i]});
      @(posedge ref_clk);
      rx_ready <= 1'b1;
      @(posedge ref_clk);
      rx_ready <= 1'b0;
    end
    repeat (3) @(posedge ref_clk);
    chk(rx_valid, 1'b0);
    // Mode write in mid-frame aborts it.
    wr(OFF_STATUS, 8'h01);
    wr(OFF_START, 8'h00);
    nfall = 0;
    pulse;
    for (int n = 0; n < 1000 && nfall < 3; n++) begin
      @(posedge ref_clk);
    end
    wr(OFF_MODE_A, 8'h0e);
    wait_irq;
    rd(OFF_STATUS, d);
    chk(d, 8'h01);
    nfall = 0;
    repeat (300) @(posedge ref_clk);
    chk(16'(nfall), 16'h0000);
    // Continuous clock output runs past eight clocks without a flag.
    wr(OFF_PORT_SEL, 8'h00);
    wr(OFF_STATUS, 8'h01);
    wr(OFF_START, 8'h00);
    repeat (1500) @(posedge ref_clk);
    chk({serial_irq_flag, nfall > 12}, 2'h1);
    wr(OFF_MODE_A, 8'h0e);
    // External clock: after a frame the port waits for clock, no new start needed.
    wr(OFF_PORT_SEL, 8'h03);
    wr(OFF_MODE_A, 8'h0f);
    ext <= 1'b1;
    repeat (110) @(posedge ref_clk);
    frame(8'h3c, 8'h96);
    wr(OFF_STATUS, 8'h01);
    pulse;
    wait_irq;
    repeat (20) @(posedge ref_clk);
    chk(p_rx, 8'h96);
    #1 chk({rx_valid, rx_data}, {1'b1, 8'h96});
    wrap_up;
  end

  initial begin
    #WD_NS;
    failures++;
    wrap_up;
  end
endmodule : tb_csp_serial_port
`default_nettype wire
